// ===== hdl/csrd_defines.svh
// Offsets, field positions, reset values and keys of the clock block.
// Assumes a byte-addressed register port with 8-bit addresses.
`ifndef CSRD_DEFINES_SVH
`define CSRD_DEFINES_SVH
// Register byte offsets
`define CSRD_OFF_OSC_CTRL  8'h00
`define CSRD_OFF_TUNING    8'h10
`define CSRD_OFF_REF_CTRL  8'h20
`define CSRD_OFF_REF_TRIM  8'h30
`define CSRD_OFF_UNLOCK    8'h40
// Oscillator control fields
`define CSRD_OSC_REQ_BIT   0
`define CSRD_OSC_SOSC_BIT  1
`define CSRD_OSC_UFRC_BIT  2
`define CSRD_OSC_FAIL_BIT  3
`define CSRD_OSC_NEW_LSB   8
`define CSRD_OSC_CUR_LSB   12
// Reference control fields
`define CSRD_REF_DIV_LSB   16
`define CSRD_REF_ON_BIT    15
`define CSRD_REF_IDLE_BIT  13
`define CSRD_REF_OE_BIT    12
`define CSRD_REF_SLP_BIT   11
`define CSRD_REF_SWREQ_BIT 9
`define CSRD_REF_ACT_BIT   8
// Trim field position
`define CSRD_TRIM_LSB      23
// Widths
`define CSRD_DIV_W         15
`define CSRD_TRIM_W        9
`define CSRD_TUNE_W        6
// Reset values
`define CSRD_DIV_RST       15'h0000
`define CSRD_TRIM_RST      9'h000
`define CSRD_TUNE_RST      6'h00
`define CSRD_SEL_RST       4'h0
// Unlock keys, values arbitrary
`define CSRD_KEY1          32'h5a5a_0f0f
`define CSRD_KEY2          32'ha5a5_f0f0
`endif

// ===== hdl/csrd_pkg.sv
// Types shared by the clock select and reference divider block.
// Assumes csrd_defines.svh for numeric constants.
package csrd_pkg;
  // Reference source codes
  typedef enum logic [3:0] {
    CSRD_SRC_SYS  = 4'h0,
    CSRD_SRC_PBUS = 4'h1,
    CSRD_SRC_POSC = 4'h2,
    CSRD_SRC_FAST = 4'h3,
    CSRD_SRC_LPWR = 4'h4,
    CSRD_SRC_SOSC = 4'h5,
    CSRD_SRC_UPLL = 4'h6,
    CSRD_SRC_SPLL = 4'h7,
    CSRD_SRC_EXT  = 4'h8
  } csrd_ref_src_t;
  // Oscillator selection code
  typedef logic [2:0] csrd_osc_sel_t;
  // Oscillator switch state
  typedef enum logic {
    CSRD_OSW_IDLE = 1'b0,
    CSRD_OSW_BUSY = 1'b1
  } csrd_osw_state_t;
endpackage

// ===== hdl/csrd_frac_div.sv
// Fractional divider: half period of div + trim/512 source edges.
// Assumes src_lvl is a slow level sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "csrd_defines.svh"
module csrd_frac_div (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     run,
  input  wire logic                     src_lvl,
  input  wire logic [`CSRD_DIV_W-1:0]   div,
  input  wire logic [`CSRD_TRIM_W-1:0]  trim,
  output logic                          clk_out,
  output logic                          boundary
);
  import csrd_pkg::*;
  logic                    src_prev_reg;
  logic [`CSRD_DIV_W-1:0]  cnt_reg;
  logic [`CSRD_TRIM_W-1:0] acc_reg;
  logic                    carry_reg;
  logic                    out_reg;
  logic                    tick;
  logic                    last;
  logic [`CSRD_TRIM_W:0]   acc_sum;

  // Source edge and end of half period
  assign tick     = src_lvl & ~src_prev_reg;
  assign last     = carry_reg ? (cnt_reg == div) : (cnt_reg == div - 15'h0001);
  assign acc_sum  = {1'b0, acc_reg} + {1'b0, trim};
  assign clk_out  = out_reg;
  // Boundary: falling output edge, or every source edge in bypass
  assign boundary = run & tick & ((div == 15'h0000) | (last & out_reg));

  // Source edge history
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_lvl;
    end
  end

  // Counter, fraction accumulator and output; stops low when not running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg   <= `CSRD_DIV_RST;
      acc_reg   <= `CSRD_TRIM_RST;
      carry_reg <= 1'b0;
      out_reg   <= 1'b0;
    end else if (!run) begin
      cnt_reg   <= `CSRD_DIV_RST;
      acc_reg   <= `CSRD_TRIM_RST;
      carry_reg <= 1'b0;
      out_reg   <= 1'b0;
    end else if (div == 15'h0000) begin
      out_reg   <= src_lvl;
    end else if (tick) begin
      if (last) begin
        cnt_reg   <= `CSRD_DIV_RST;
        out_reg   <= ~out_reg;
        acc_reg   <= acc_sum[`CSRD_TRIM_W-1:0];
        carry_reg <= acc_sum[`CSRD_TRIM_W];
      end else begin
        cnt_reg   <= cnt_reg + 15'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/csrd_top.sv
// Clock select bits, fast RC tuning and reference clock generator.
// Assumes synchronous inputs and one clock; source clocks arrive
// as levels well below half of clk_sys.
//
// Contract
// - Clock monitor failure sets the fail flag
// - USB clock from fast RC when selected
// - Secondary oscillator enable follows its bit
// - Switch request starts switch, reads zero after
// - Six-bit signed fast RC trim value
// - Fifteen-bit divider in bits 30..16
// - Generator runs only while enabled
// - Stop in idle halts generator in idle
// - Output enable drives clock onto pin
// - Run in sleep keeps output in sleep
// - Run in sleep ignored for sources 0,1
// - Enabled: new values wait for switch request
// - Status bit shows clock request active
// - Four-bit source select picks reference source
// - Trim adds N/512 to the divider
// - Enabled: trim writes wait for switch
// - Unimplemented bits read zero, ignore writes
// - New oscillator code loaded from configuration
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "csrd_defines.svh"
module csrd_top (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  input  wire csrd_pkg::csrd_osc_sel_t cfg_new_osc,
  input  wire logic                   clock_fail_detect,
  input  wire logic                   osc_switch_done,
  output logic                        osc_switch_busy,
  output csrd_pkg::csrd_osc_sel_t     osc_target,
  output logic                        usb_clk_from_fast_rc,
  output logic                        sosc_enable,
  output logic [`CSRD_TUNE_W-1:0]     fast_rc_trim,
  input  wire logic [8:0]             ref_src_lvl,
  input  wire logic                   dev_idle,
  input  wire logic                   dev_sleep,
  output logic                        ref_clock_out_pin,
  output logic                        ref_clock_out_oe,
  output logic                        ref_request_active
);
  import csrd_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Address hit, shared by read and write decode
  function automatic logic csrd_hit(input logic [7:0] a, input logic [7:0] off);
    csrd_hit = (a == off);
  endfunction
  // Sleep stops output: system and bus clocks stop regardless
  function automatic logic csrd_sleep_stops(input csrd_ref_src_t s, input logic keep_run);
    csrd_sleep_stops = (s == CSRD_SRC_SYS) | (s == CSRD_SRC_PBUS) | ~keep_run;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic                    unlock_stage_reg;
  logic                    unlocked_reg;
  logic                    strap_done_reg;
  csrd_osw_state_t         osw_state_reg;
  csrd_osc_sel_t           new_osc_reg;
  csrd_osc_sel_t           cur_osc_reg;
  logic                    fail_reg;
  logic                    ufrc_reg;
  logic                    sosc_reg;
  logic [`CSRD_TUNE_W-1:0] tune_reg;
  logic                    on_reg;
  logic                    idl_off_reg;
  logic                    oe_reg;
  logic                    slp_run_reg;
  logic                    swreq_reg;
  logic [`CSRD_DIV_W-1:0]  div_sw_reg;
  logic [`CSRD_TRIM_W-1:0] trim_sw_reg;
  csrd_ref_src_t           sel_sw_reg;
  logic [`CSRD_DIV_W-1:0]  div_act_reg;
  logic [`CSRD_TRIM_W-1:0] trim_act_reg;
  csrd_ref_src_t           sel_act_reg;
  logic [31:0]             rdata_reg;
  logic                    wr_osc;
  logic                    wr_tun;
  logic                    wr_ref;
  logic                    wr_trim;
  logic                    wr_key;
  logic                    run;
  logic                    src_lvl;
  logic                    gen_clk;
  logic                    boundary;
  logic                    apply;
  logic                    sw_set;

  // ----------------------------------------
  // Write decode and unlock
  // ----------------------------------------
  // Locked writes are dropped silently
  assign wr_key  = reg_wr & csrd_hit(reg_addr, `CSRD_OFF_UNLOCK);
  assign wr_osc  = reg_wr & unlocked_reg & csrd_hit(reg_addr, `CSRD_OFF_OSC_CTRL);
  assign wr_tun  = reg_wr & unlocked_reg & csrd_hit(reg_addr, `CSRD_OFF_TUNING);
  assign wr_ref  = reg_wr & unlocked_reg & csrd_hit(reg_addr, `CSRD_OFF_REF_CTRL);
  assign wr_trim = reg_wr & unlocked_reg & csrd_hit(reg_addr, `CSRD_OFF_REF_TRIM);

  // Two keys in order open; any other key write closes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unlock_stage_reg <= 1'b0;
      unlocked_reg     <= 1'b0;
    end else if (wr_key) begin
      unlock_stage_reg <= (reg_wdata == `CSRD_KEY1);
      unlocked_reg     <= unlock_stage_reg & (reg_wdata == `CSRD_KEY2);
    end
  end

  // ----------------------------------------
  // Oscillator control
  // ----------------------------------------
  // Straps caught once after reset release, not under async reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_reg <= 1'b0;
      new_osc_reg    <= 3'h0;
    end else begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg) begin
        new_osc_reg <= cfg_new_osc;
      end else if (wr_osc) begin
        new_osc_reg <= reg_wdata[`CSRD_OSC_NEW_LSB +: 3];
      end
    end
  end

  // Switch handshake; a new request beats a same-cycle done
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osw_state_reg <= CSRD_OSW_IDLE;
      cur_osc_reg   <= 3'h0;
    end else begin
      if (!strap_done_reg) begin
        cur_osc_reg <= cfg_new_osc;
      end else if (osw_state_reg == CSRD_OSW_BUSY && osc_switch_done) begin
        cur_osc_reg <= new_osc_reg;
      end
      case (osw_state_reg)
        CSRD_OSW_IDLE: begin
          if (wr_osc && reg_wdata[`CSRD_OSC_REQ_BIT]) begin
            osw_state_reg <= CSRD_OSW_BUSY;
          end
        end
        CSRD_OSW_BUSY: begin
          if (osc_switch_done && !(wr_osc && reg_wdata[`CSRD_OSC_REQ_BIT])) begin
            osw_state_reg <= CSRD_OSW_IDLE;
          end
        end
        default: osw_state_reg <= CSRD_OSW_IDLE;
      endcase
    end
  end

  // Fail flag sticky; software writes zero to clear, set wins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fail_reg <= 1'b0;
    end else if (clock_fail_detect) begin
      fail_reg <= 1'b1;
    end else if (wr_osc && !reg_wdata[`CSRD_OSC_FAIL_BIT]) begin
      fail_reg <= 1'b0;
    end
  end

  // Plain enables and fast RC tuning
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ufrc_reg <= 1'b0;
      sosc_reg <= 1'b0;
      tune_reg <= `CSRD_TUNE_RST;
    end else begin
      if (wr_osc) begin
        ufrc_reg <= reg_wdata[`CSRD_OSC_UFRC_BIT];
        sosc_reg <= reg_wdata[`CSRD_OSC_SOSC_BIT];
      end
      if (wr_tun) begin
        tune_reg <= reg_wdata[`CSRD_TUNE_W-1:0];
      end
    end
  end

  assign osc_switch_busy      = (osw_state_reg == CSRD_OSW_BUSY);
  assign osc_target           = new_osc_reg;
  assign usb_clk_from_fast_rc = ufrc_reg;
  assign sosc_enable          = sosc_reg;
  assign fast_rc_trim         = tune_reg;

  // ----------------------------------------
  // Reference generator control
  // ----------------------------------------
  // Software-side copies; bit 31 and reserved bits are not stored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      on_reg      <= 1'b0;
      idl_off_reg <= 1'b0;
      oe_reg      <= 1'b0;
      slp_run_reg <= 1'b0;
      div_sw_reg  <= `CSRD_DIV_RST;
      sel_sw_reg  <= CSRD_SRC_SYS;
      trim_sw_reg <= `CSRD_TRIM_RST;
    end else begin
      if (wr_ref) begin
        on_reg      <= reg_wdata[`CSRD_REF_ON_BIT];
        idl_off_reg <= reg_wdata[`CSRD_REF_IDLE_BIT];
        oe_reg      <= reg_wdata[`CSRD_REF_OE_BIT];
        slp_run_reg <= reg_wdata[`CSRD_REF_SLP_BIT];
        div_sw_reg  <= reg_wdata[`CSRD_REF_DIV_LSB +: `CSRD_DIV_W];
        sel_sw_reg  <= csrd_ref_src_t'(reg_wdata[3:0]);
      end
      if (wr_trim) begin
        trim_sw_reg <= reg_wdata[`CSRD_TRIM_LSB +: `CSRD_TRIM_W];
      end
    end
  end

  // Idle and sleep gating of the generator
  assign run = on_reg
             & ~(idl_off_reg & dev_idle)
             & ~(dev_sleep & csrd_sleep_stops(sel_act_reg, slp_run_reg));
  assign ref_request_active = run;

  // Switch request: software sets, hardware clears, set wins
  assign sw_set = wr_ref & reg_wdata[`CSRD_REF_SWREQ_BIT];
  assign apply  = ~on_reg | (swreq_reg & (~run | boundary));
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      swreq_reg <= 1'b0;
    end else if (sw_set) begin
      swreq_reg <= 1'b1;
    end else if (swreq_reg && apply) begin
      swreq_reg <= 1'b0;
    end
  end

  // Applied values change only at a boundary while running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_act_reg  <= `CSRD_DIV_RST;
      trim_act_reg <= `CSRD_TRIM_RST;
      sel_act_reg  <= CSRD_SRC_SYS;
    end else if (apply) begin
      div_act_reg  <= div_sw_reg;
      trim_act_reg <= trim_sw_reg;
      sel_act_reg  <= sel_sw_reg;
    end
  end

  // Reserved codes select nothing
  assign src_lvl = (sel_act_reg <= CSRD_SRC_EXT) ? ref_src_lvl[sel_act_reg] : 1'b0;

  csrd_frac_div u_div (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .run      (run),
    .src_lvl  (src_lvl),
    .div      (div_act_reg),
    .trim     (trim_act_reg),
    .clk_out  (gen_clk),
    .boundary (boundary)
  );

  // Pin carries the clock only when enabled
  assign ref_clock_out_pin = oe_reg & gen_clk;
  assign ref_clock_out_oe  = oe_reg;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= 32'h0000_0000;
      if (csrd_hit(reg_addr, `CSRD_OFF_OSC_CTRL)) begin
        rdata_reg[`CSRD_OSC_CUR_LSB +: 3] <= cur_osc_reg;
        rdata_reg[`CSRD_OSC_NEW_LSB +: 3] <= new_osc_reg;
        rdata_reg[`CSRD_OSC_FAIL_BIT]     <= fail_reg;
        rdata_reg[`CSRD_OSC_UFRC_BIT]     <= ufrc_reg;
        rdata_reg[`CSRD_OSC_SOSC_BIT]     <= sosc_reg;
        rdata_reg[`CSRD_OSC_REQ_BIT]      <= osc_switch_busy;
      end else if (csrd_hit(reg_addr, `CSRD_OFF_TUNING)) begin
        rdata_reg[`CSRD_TUNE_W-1:0] <= tune_reg;
      end else if (csrd_hit(reg_addr, `CSRD_OFF_REF_CTRL)) begin
        rdata_reg[`CSRD_REF_DIV_LSB +: `CSRD_DIV_W] <= div_sw_reg;
        rdata_reg[`CSRD_REF_ON_BIT]    <= on_reg;
        rdata_reg[`CSRD_REF_IDLE_BIT]  <= idl_off_reg;
        rdata_reg[`CSRD_REF_OE_BIT]    <= oe_reg;
        rdata_reg[`CSRD_REF_SLP_BIT]   <= slp_run_reg;
        rdata_reg[`CSRD_REF_SWREQ_BIT] <= swreq_reg;
        rdata_reg[`CSRD_REF_ACT_BIT]   <= run;
        rdata_reg[3:0]                 <= sel_sw_reg;
      end else if (csrd_hit(reg_addr, `CSRD_OFF_REF_TRIM)) begin
        rdata_reg[`CSRD_TRIM_LSB +: `CSRD_TRIM_W] <= trim_sw_reg;
      end
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_fail_flag_set: assert property (
    clock_fail_detect |=> fail_reg)
    else $error("fail flag not set after monitor event");
  chk_usb_source: assert property (
    wr_osc |=> usb_clk_from_fast_rc == $past(reg_wdata[`CSRD_OSC_UFRC_BIT]))
    else $error("usb source select not applied");
  chk_sosc_enable: assert property (
    wr_osc |=> sosc_enable == $past(reg_wdata[`CSRD_OSC_SOSC_BIT]))
    else $error("secondary oscillator enable wrong");
  chk_switch_done: assert property (
    (osc_switch_busy && osc_switch_done && !wr_osc) |=> !osc_switch_busy && cur_osc_reg == new_osc_reg)
    else $error("oscillator switch did not complete");
  chk_locked_drop: assert property (
    (reg_wr && !unlocked_reg && csrd_hit(reg_addr, `CSRD_OFF_TUNING)) |=> $stable(tune_reg))
    else $error("locked write changed tuning");
  chk_trim_load: assert property (
    wr_tun |=> fast_rc_trim == $past(reg_wdata[5:0]))
    else $error("tuning value not loaded");
  chk_top_bit_zero: assert property (
    $past(reg_rd) && $past(csrd_hit(reg_addr, `CSRD_OFF_REF_CTRL)) |-> reg_rdata[31] == 1'b0
      && reg_rdata[14] == 1'b0 && reg_rdata[10] == 1'b0 && reg_rdata[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
  chk_off_quiet: assert property (
    !on_reg ##1 !on_reg |-> !gen_clk && !ref_request_active)
    else $error("generator active while disabled");
  chk_idle_halt: assert property (
    (on_reg && idl_off_reg && dev_idle) |=> !gen_clk)
    else $error("generator ran in idle with stop set");
  chk_pin_gate: assert property (
    !oe_reg |-> !ref_clock_out_pin)
    else $error("pin driven without output enable");
  chk_sleep_halt: assert property (
    (dev_sleep && (!slp_run_reg || sel_act_reg == CSRD_SRC_SYS || sel_act_reg == CSRD_SRC_PBUS))
      |=> !gen_clk)
    else $error("output ran in sleep");
  chk_pending_hold: assert property (
    (on_reg && !swreq_reg) |=> $stable(div_act_reg) && $stable(trim_act_reg) && $stable(sel_act_reg))
    else $error("pending value applied without switch request");
  chk_switch_clear: assert property (
    (on_reg && swreq_reg && run && boundary && !sw_set) |=> !swreq_reg && div_act_reg == $past(div_sw_reg))
    else $error("switch request not cleared at boundary");
  chk_bypass: assert property (
    (run && div_act_reg == 15'h0000) ##1 (run && div_act_reg == 15'h0000) |-> gen_clk == $past(src_lvl))
    else $error("zero divider did not pass source");

  cov_osc_switch: cover property (osc_switch_busy ##[1:20] !osc_switch_busy);
  cov_div_switch: cover property (on_reg && swreq_reg ##[1:200] !swreq_reg);
  cov_pin_toggle: cover property (ref_clock_out_pin ##[1:50] !ref_clock_out_pin);
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the clock select and reference divider block.
// Assumes csrd_top with its assertions inside; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "csrd_defines.svh"
module tb_top;
  import csrd_pkg::*;
  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  A_OSC = `CSRD_OFF_OSC_CTRL;
  localparam logic [7:0]  A_RCT = `CSRD_OFF_TUNING;
  localparam logic [7:0]  A_REF = `CSRD_OFF_REF_CTRL;
  localparam logic [7:0]  A_TRM = `CSRD_OFF_REF_TRIM;
  localparam logic [7:0]  A_UNL = `CSRD_OFF_UNLOCK;
  localparam logic [31:0] ON    = 32'h0000_8000;
  localparam logic [31:0] OE    = 32'h0000_1000;
  localparam logic [31:0] D1    = 32'h0001_0000;
  localparam logic [31:0] D2    = 32'h0002_0000;
  logic                   clk_sys = 1'b0;
  logic                   reset_n = 1'b0;
  logic [7:0]             reg_addr = 8'h00;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata;
  csrd_osc_sel_t          cfg_new_osc = 3'h5;
  logic                   clock_fail_detect = 1'b0;
  logic                   osc_switch_done = 1'b0;
  logic                   osc_switch_busy;
  csrd_osc_sel_t          osc_target;
  logic                   usb_clk_from_fast_rc;
  logic                   sosc_enable;
  logic [5:0]             fast_rc_trim;
  logic [8:0]             ref_src_lvl = 9'h000;
  logic [8:0]             mask = 9'h1ff;
  logic [2:0]             ph = 3'h0;
  logic                   dev_idle = 1'b0;
  logic                   dev_sleep = 1'b0;
  logic                   ref_clock_out_pin;
  logic                   ref_clock_out_oe;
  logic                   ref_request_active;
  int                     fails = 0;
  int                     n_compared = 0;
  int                     cyc = 0;
  logic [31:0]            d;
  logic [31:0]            q;
  int                     c;
  logic [31:0]            cfg [7] = '{ON|OE|D1|32'h2003, ON|OE|D1|32'h3, ON|OE|D1|32'h803, ON|OE|D1|32'h3,
                                      ON|OE|D1|32'h800, OE|D1|32'h3, ON|D1|32'h3};
  logic [2:0]             ise [7] = '{3'b100, 3'b101, 3'b011, 3'b010, 3'b010, 3'b000, 3'b001};
  csrd_top i_csrd_top (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_new_osc(cfg_new_osc),
    .clock_fail_detect(clock_fail_detect), .osc_switch_done(osc_switch_done), .osc_switch_busy(osc_switch_busy),
    .osc_target(osc_target), .usb_clk_from_fast_rc(usb_clk_from_fast_rc), .sosc_enable(sosc_enable),
    .fast_rc_trim(fast_rc_trim), .ref_src_lvl(ref_src_lvl), .dev_idle(dev_idle), .dev_sleep(dev_sleep),
    .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_oe(ref_clock_out_oe),
    .ref_request_active(ref_request_active));
  // Clock, and source clocks of eight cycles, well under half of clk_sys
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    ph <= ph + 3'h1;
    ref_src_lvl <= {9{ph[2]}} & mask;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Guard against a hang; the full run needs well under 15000 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken just after the edge that follows the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Full reconfiguration: switch off first so new values apply at once
  task automatic setref(input logic [31:0] v);
    wr(A_REF, 32'h0);
    wr(A_REF, v & ~ON);
    wr(A_REF, v);
  endtask
  // Cycles until the next rising pin edge; 400 means none seen
  task automatic rise(output int n);
    logic p;
    n = 0;
    p = ref_clock_out_pin;
    do begin
      @(posedge clk_sys);
      n++;
      if (!p && ref_clock_out_pin) break;
      p = ref_clock_out_pin;
    end while (n < 400);
  endtask
  task automatic period(input int exp);
    rise(c);
    rise(c);
    cmp(c, exp);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp(osc_target, 3'h5);
    rd(A_OSC, d);
    cmp(d & 32'h770f, 32'h5500);
    rd(A_REF, d);
    cmp(d, 32'h0);
    wr(A_RCT, 32'h3f);
    rd(A_RCT, d);
    cmp(d, 32'h0);
    $display("test reset_and_lock done");
    wr(A_UNL, `CSRD_KEY1);
    wr(A_UNL, `CSRD_KEY2);
    // Lowest step, highest step, then centre; outputs settle by the falling edge
    foreach (cfg[i]) begin
      d = (i == 0) ? 32'hffff_ffe0 : ((i == 1) ? 32'h1f : 32'h0);
      wr(A_RCT, d);
      @(negedge clk_sys);
      cmp(fast_rc_trim, d[5:0]);
      rd(A_RCT, q);
      cmp(q, {26'h0, d[5:0]});
    end
    wr(8'h50, 32'hffff_ffff);
    rd(8'h50, d);
    cmp(d, 32'h0);
    $display("test tuning done");
    wr(A_OSC, 32'h0000_0207);
    @(negedge clk_sys);
    cmp(osc_switch_busy, 1'b1);
    cmp(osc_target, 3'h2);
    cmp({usb_clk_from_fast_rc, sosc_enable}, 2'b11);
    rd(A_OSC, d);
    cmp(d & 32'h770f, 32'h5207);
    @(posedge clk_sys);
    osc_switch_done <= 1'b1;
    @(posedge clk_sys);
    osc_switch_done <= 1'b0;
    rd(A_OSC, d);
    cmp(d & 32'h770f, 32'h2206);
    @(posedge clk_sys);
    clock_fail_detect <= 1'b1;
    @(posedge clk_sys);
    clock_fail_detect <= 1'b0;
    rd(A_OSC, d);
    cmp(d & 32'h0008, 32'h0008);
    wr(A_OSC, 32'h0000_0200);
    @(negedge clk_sys);
    cmp({usb_clk_from_fast_rc, sosc_enable}, 2'b00);
    rd(A_OSC, d);
    cmp(d & 32'h000f, 32'h0000);
    $display("test oscillator done");
    wr(A_REF, 32'h8000_44f0);
    rd(A_REF, d);
    cmp(d, 32'h0);
    for (int s = 0; s < 9; s++) begin
      mask <= 9'h1 << s;
      setref(ON | OE | D1 | s);
      period(16);
    end
    mask <= 9'h1ff;
    $display("test source select done");
    setref(ON | OE | D1 | 32'h3);
    wr(A_REF, ON | OE | D2 | 32'h3);
    period(16);
    wr(A_TRM, 32'h8000_0000);
    period(16);
    wr(A_REF, ON | OE | D2 | 32'h203);
    repeat (60) @(posedge clk_sys);
    rd(A_REF, d);
    cmp(d, ON | OE | D2 | 32'h103);
    period(40);
    wr(A_REF, 32'h0);
    wr(A_TRM, 32'h0);
    setref(ON | OE | 32'h3);
    period(8);
    $display("test divider done");
    foreach (cfg[i]) begin
      setref(cfg[i]);
      dev_idle <= ise[i][2];
      dev_sleep <= ise[i][1];
      repeat (3) @(posedge clk_sys);
      cmp(ref_request_active, ise[i][0]);
      cmp(ref_clock_out_oe, cfg[i][12]);
      rd(A_REF, d);
      cmp(d[8], ise[i][0]);
      period((ise[i][0] && cfg[i][12]) ? 16 : 400);
      dev_idle <= 1'b0;
      dev_sleep <= 1'b0;
    end
    $display("test modes done");
    wr(A_REF, 32'h0);
    wr(A_TRM, 32'h007f_ffff);
    rd(A_TRM, d);
    cmp(d, 32'h0);
    wr(A_TRM, 32'hffff_ffff);
    rd(A_TRM, d);
    cmp(d, 32'hff80_0000);
    wr(A_UNL, 32'h0);
    wr(A_RCT, 32'h1);
    rd(A_RCT, d);
    cmp(d, 32'h0);
    $display("test trim and relock done");
    end_sim();
  end
endmodule
`default_nettype wire
